/* design/eepc_ctrl.sv */
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module eepc_ctrl #(
    parameter int MS_CYCLES = eepc_pkg::MS_CYCLES, // Cycles per ms of pulse
    parameter int RECOVER_CYCLES = eepc_pkg::RECOVER_CYCLES, // Wait after pulse
    parameter int SYNC_CYCLES = eepc_pkg::SYNC_CYCLES // Clocks per machine cycle
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic chip_select_n, // Host chip select
    input wire logic host_read_n, // Host read strobe
    input wire logic host_write_n, // Host write strobe
    input wire logic register_select_line, // Data/status or command/data
    input wire logic [7:0] host_data_in, // Host data bus, sensed
    output logic [7:0] host_data_out, // Host data bus, driven
    output logic host_data_oe, // Host data bus drive enable
    output logic output_full_irq, // Unread output byte
    output logic input_emptied_irq, // Input byte consumed
    input wire logic bank_grant, // Local bus granted
    output logic bank_request_n, // Local bus request
    output logic memory_chip_enable_n, // Memory chip enable
    output logic memory_output_enable_n, // Memory read strobe
    output logic programming_enable_n, // Programming voltage on when low
    input wire logic [11:0] memory_address_low_in, // Low address, sensed
    output logic [11:0] memory_address_low_out, // Low address, driven
    output logic memory_address_low_oe, // Low address drive enable
    output logic [1:0] memory_address_high, // Address bits 13:12
    input wire logic [7:0] memory_data_in, // Memory data, sensed
    output logic [7:0] memory_data_out, // Memory data, driven
    output logic memory_data_oe, // Memory data drive enable
    input wire logic [3:0] expander_nibble_port_in, // Expander port, sensed
    output logic [3:0] expander_nibble_port_out, // Expander port, driven
    output logic expander_nibble_port_oe, // Expander port drive enable
    output logic expander_latch_strobe, // Expander nibble latch
    output logic cycle_sync // Machine cycle pulse
);
    eepc_pkg::eepc_state_type state; // Sequencer state
    eepc_pkg::eepc_state_type next_state; // Its next value
    logic host_rd; // Qualified host read
    logic host_wr; // Qualified host write
    logic [7:0] in_data; // Input register
    logic in_is_cmd; // Input byte is a command
    logic in_full; // Input register not yet consumed
    logic consume; // Sequencer takes the input byte
    logic [7:0] cmd; // Current command
    logic wait_data; // Command wants more data bytes
    logic [1:0] byte_idx; // Next data byte index
    logic [13:0] addr; // Memory address
    logic [7:0] wdata; // Byte to program
    logic [7:0] pulse_ms; // Programming pulse width in ms
    logic start; // One-cycle start of a memory operation
    logic illegal; // One-cycle illegal command flag
    logic [7:0] out_data; // Output register
    logic out_full; // Output register unread
    logic [31:0] cnt; // Cycle counter inside a state
    logic [7:0] ms_left; // Whole ms still to pulse
    logic [7:0] sync_cnt; // Machine cycle divider
    logic [7:0] status; // Status byte
    logic is_write; // Current operation programs
    logic pulse_end; // Last cycle of the pulse
    logic owns_bus; // Operation active and bus granted

    // Strobes only count while chip select is low, so other peripherals
    // can share the host bus.
    assign host_rd = !chip_select_n && !host_read_n;
    assign host_wr = !chip_select_n && !host_write_n;
    assign consume = in_full && (state == eepc_pkg::S_IDLE);
    assign is_write = (cmd == eepc_pkg::CMD_WRITE);
    assign pulse_end = (ms_left == 8'h00) && (cnt == 32'(MS_CYCLES - 1));
    assign status = {4'h0, wait_data, state != eepc_pkg::S_IDLE, in_full, out_full};

    // The host bus answers one cycle late; a read strobe held longer than
    // one cycle simply repeats the answer and clears output-full once more.
    // Host read: selected register appears in the next cycle only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            host_data_out <= 8'h00;
            host_data_oe <= 1'b0;
        end else begin
            host_data_oe <= host_rd;
            if (host_rd) begin
                host_data_out <= register_select_line ? status : out_data;
            end
        end
    end

    // Hazard: a host that ignores input-emptied overwrites the pending byte;
    // the status byte lets a polling host avoid that.
    // Host write: byte and its kind are latched; a new write wins over consumption
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_data <= 8'h00;
            in_is_cmd <= 1'b0;
            in_full <= 1'b0;
        end else if (host_wr) begin
            in_data <= host_data_in;
            in_is_cmd <= register_select_line;
            in_full <= 1'b1;
        end else if (consume) begin
            in_full <= 1'b0;
        end
    end

    assign input_emptied_irq = !in_full;

    // Only three commands are decoded; any other code is reported as illegal
    // and leaves the parser waiting for a fresh command byte.
    // Address high byte keeps only its low six bits, the rest is ignored.
    // Command parser: command byte, then high address, low address, data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd <= 8'h00;
            wait_data <= 1'b0;
            byte_idx <= 2'h0;
            addr <= 14'h0000;
            wdata <= 8'h00;
            pulse_ms <= eepc_pkg::PULSE_RESET;
            start <= 1'b0;
            illegal <= 1'b0;
        end else begin
            start <= 1'b0;
            illegal <= 1'b0;
            if (consume && in_is_cmd) begin
                // A new command aborts any half-sent one
                cmd <= in_data;
                byte_idx <= 2'h0;
                wait_data <= (in_data == eepc_pkg::CMD_READ) ||
                    (in_data == eepc_pkg::CMD_WRITE) || (in_data == eepc_pkg::CMD_PULSE);
                illegal <= !((in_data == eepc_pkg::CMD_READ) ||
                    (in_data == eepc_pkg::CMD_WRITE) || (in_data == eepc_pkg::CMD_PULSE));
            end else if (consume && wait_data) begin
                if (cmd == eepc_pkg::CMD_PULSE) begin
                    pulse_ms <= in_data;
                    wait_data <= 1'b0;
                end else begin
                    case (byte_idx)
                        2'h0: begin
                            addr[13:8] <= in_data[5:0];
                            byte_idx <= 2'h1;
                        end
                        2'h1: begin
                            addr[7:0] <= in_data;
                            byte_idx <= 2'h2;
                            if (!is_write) begin
                                start <= 1'b1;
                                wait_data <= 1'b0;
                            end
                        end
                        default: begin
                            wdata <= in_data;
                            start <= 1'b1;
                            wait_data <= 1'b0;
                        end
                    endcase
                end
            end
            // Stray data bytes with no command pending are dropped
        end
    end

    // Trade-off: a read strobe landing on the capture cycle loses its clear,
    // so the freshly read byte is never lost to a stale read.
    // Output register: a set from the sequencer wins over a host read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_data <= 8'h00;
            out_full <= 1'b0;
        end else if (state == eepc_pkg::S_READ) begin
            out_data <= memory_data_in;
            out_full <= 1'b1;
        end else if (illegal) begin
            out_data <= eepc_pkg::ILLEGAL_CODE;
            out_full <= 1'b1;
        end else if (host_rd && !register_select_line) begin
            out_full <= 1'b0;
        end
    end

    assign output_full_irq = out_full;

    // Waiting for the grant has no limit; a stuck arbiter stalls the block
    // with the request held low.
    // Sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            eepc_pkg::S_IDLE: if (start) next_state = eepc_pkg::S_REQ;
            eepc_pkg::S_REQ: if (bank_grant) next_state = eepc_pkg::S_ADDR;
            eepc_pkg::S_ADDR: next_state = is_write ? eepc_pkg::S_EXPANDER_LATCH_STROBE : eepc_pkg::S_READ;
            eepc_pkg::S_READ: next_state = eepc_pkg::S_DONE;
            eepc_pkg::S_EXPANDER_LATCH_STROBE: if (pulse_end) next_state = eepc_pkg::S_RECOV;
            eepc_pkg::S_RECOV: begin
                if (cnt == 32'(RECOVER_CYCLES - 1)) next_state = eepc_pkg::S_DONE;
            end
            eepc_pkg::S_DONE: next_state = eepc_pkg::S_IDLE;
            default: next_state = eepc_pkg::S_IDLE;
        endcase
    end

    // Sequencer state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= eepc_pkg::S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // The counter is wide enough for any recovery setting; the pulse itself
    // is counted one ms at a time, so its width is limited to 255 ms.
    // Pulse and recovery timing; ms are counted apart so long pulses stay cheap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 32'h0;
            ms_left <= 8'h00;
        end else if (next_state != state) begin
            cnt <= 32'h0;
            // A zero width still gives one ms rather than none
            ms_left <= (pulse_ms == 8'h00) ? 8'h00 : pulse_ms - 8'h01;
        end else if (state == eepc_pkg::S_EXPANDER_LATCH_STROBE && cnt == 32'(MS_CYCLES - 1)) begin
            cnt <= 32'h0;
            ms_left <= ms_left - 8'h01;
        end else begin
            cnt <= cnt + 32'h1;
        end
    end

    // Request stays low through recovery so no other master touches the bank
    // while the programming voltage decays.
    // Strobes decoded from state by comparing the whole state value, not taken from single state bits
    assign bank_request_n = (state == eepc_pkg::S_IDLE) || (state == eepc_pkg::S_DONE);
    assign memory_chip_enable_n = !((state == eepc_pkg::S_ADDR) ||
        (state == eepc_pkg::S_READ) || (state == eepc_pkg::S_EXPANDER_LATCH_STROBE));
    assign memory_output_enable_n = (state != eepc_pkg::S_READ);
    assign programming_enable_n = (state != eepc_pkg::S_EXPANDER_LATCH_STROBE);
    assign owns_bus = bank_grant && !bank_request_n && (state != eepc_pkg::S_REQ);

    // The sensed address input is not needed: the block never reads
    // back the address it drives; sensed memory data is used for reads.
    // Low address and data buses float whenever the grant is missing; address bits 13:12 are always driven
    assign memory_address_low_out = addr[11:0];
    assign memory_address_low_oe = owns_bus;
    assign memory_address_high = addr[13:12];
    assign memory_data_out = wdata;
    assign memory_data_oe = owns_bus && is_write && (state != eepc_pkg::S_RECOV);

    // Limitation: the expander port only ever carries the command nibble;
    // its sensed input is not used.
    // Expander gets the command nibble, latched while the address is set up
    assign expander_nibble_port_out = cmd[3:0];
    assign expander_nibble_port_oe = (state == eepc_pkg::S_ADDR);
    assign expander_latch_strobe = (state == eepc_pkg::S_ADDR);

    // Divider free-runs from reset; the pulse is registered so it is clean.
    // Machine cycle divider and its sync pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_cnt <= 8'h00;
            cycle_sync <= 1'b0;
        end else begin
            sync_cnt <= (sync_cnt == 8'(SYNC_CYCLES - 1)) ? 8'h00 : sync_cnt + 8'h01;
            cycle_sync <= (sync_cnt == 8'(SYNC_CYCLES - 1));
        end
    end

    // Checks below run only outside reset; the timing ones assume the
    // shortened counts stay at least eight cycles long.
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence pulse_open_s;
        $fell(programming_enable_n);
    endsequence
    sequence pulse_hold_s;
        !programming_enable_n [*8];
    endsequence
    sequence recover_s;
        $rose(programming_enable_n) ##0 (!bank_request_n && memory_chip_enable_n) [*8];
    endsequence

    grant_wait_a: assert property ((state == eepc_pkg::S_REQ && !bank_grant) |=>
        memory_chip_enable_n) else $error("chip enable without grant");
    request_held_a: assert property (!memory_chip_enable_n |-> !bank_request_n)
        else $error("chip enable without request");
    read_strobe_a: assert property (!memory_output_enable_n |->
        (!memory_chip_enable_n && programming_enable_n)) else $error("bad read strobe");
    read_capture_a: assert property (!memory_output_enable_n |=>
        (out_full && memory_output_enable_n && memory_chip_enable_n))
        else $error("read not captured");
    pulse_width_a: assert property (pulse_open_s |-> pulse_hold_s)
        else $error("pulse too short");
    // Recovery keeps the bus but leaves the voltage off and the chips disabled
    recover_wait_a: assert property ((state == eepc_pkg::S_RECOV) |->
        (programming_enable_n && memory_chip_enable_n && !bank_request_n))
        else $error("recovery state drives strobes");
    recover_hold_a: assert property ($rose(programming_enable_n) |-> recover_s)
        else $error("recovery too short");
    bus_float_a: assert property (!bank_grant |->
        (!memory_address_low_oe && !memory_data_oe)) else $error("bus driven without grant");
    status_read_a: assert property ((host_rd && register_select_line) |=>
        (host_data_oe && host_data_out == $past(status))) else $error("status not read");
    select_gate_a: assert property (chip_select_n |=> !host_data_oe)
        else $error("answer without chip select");
    full_clear_a: assert property ((host_rd && !register_select_line &&
        state != eepc_pkg::S_READ && !illegal) |=> !output_full_irq)
        else $error("output full not cleared");
    write_take_a: assert property (host_wr |=> (!input_emptied_irq &&
        in_data == $past(host_data_in))) else $error("write not captured");
    sync_space_a: assert property (cycle_sync |=> !cycle_sync [*2])
        else $error("sync too frequent");
    // Machine cycle pulse lines up with the divider wrap
    sync_phase_a: assert property (cycle_sync |-> (sync_cnt == 8'h00))
        else $error("sync off its divider");
    // A started operation asks for the bus on the very next cycle
    request_first_a: assert property (start |=> !bank_request_n)
        else $error("no request after start");
    // The done state hands the bus back with the chips disabled
    request_release_a: assert property ((state == eepc_pkg::S_DONE) |->
        (bank_request_n && memory_chip_enable_n)) else $error("bus kept after done");
    // Programming voltage only on a write that drives its data
    expander_latch_strobe_write_a: assert property (!programming_enable_n |->
        (is_write && !memory_chip_enable_n && memory_data_oe && memory_output_enable_n))
        else $error("pulse outside a write");
    // Latch strobe is a single cycle per operation
    latch_single_a: assert property (expander_latch_strobe |=> !expander_latch_strobe)
        else $error("latch strobe too long");
    // Nibble is driven whenever it is latched
    nibble_drive_a: assert property (expander_latch_strobe |->
        (expander_nibble_port_oe && expander_nibble_port_out == cmd[3:0]))
        else $error("nibble not driven");
    // Consumed byte frees the input side unless a new write lands at once
    input_free_a: assert property ((consume && !host_wr) |=> input_emptied_irq)
        else $error("input not freed");
    // Illegal command leaves its marker byte for the host
    illegal_mark_a: assert property (illegal |=>
        (output_full_irq && out_data == eepc_pkg::ILLEGAL_CODE))
        else $error("illegal command not reported");
    // Read walk: address phase with chip enable, then one output-enable cycle
    sequence addr_phase_s;
        !memory_chip_enable_n && memory_output_enable_n && expander_latch_strobe;
    endsequence
    sequence read_phase_s;
        !memory_chip_enable_n && !memory_output_enable_n;
    endsequence
    read_order_a: assert property ((state == eepc_pkg::S_ADDR && !is_write) |->
        addr_phase_s ##1 read_phase_s) else $error("read walk out of order");
    // Chip enable, low address and data stay off the local bus before the grant is seen
    grant_first_a: assert property ((state == eepc_pkg::S_REQ) |->
        (memory_chip_enable_n && !memory_address_low_oe && !memory_data_oe))
        else $error("bus used while requesting");
endmodule : eepc_ctrl

/* design/eepc_pkg.sv */
package eepc_pkg;
    // Clock rate in MHz (10 ns period)
    localparam int CLK_MHZ = 100;
    // Default programming pulse width, in ms
    localparam int PULSE_MS = 10;
    // Cycles in one ms of programming pulse
    localparam int MS_CYCLES = 1000 * CLK_MHZ;
    // Least recovery time after the pulse, in us
    localparam int RECOVER_US = 100;
    // Recovery must be strictly longer, hence one spare cycle
    localparam int RECOVER_CYCLES = RECOVER_US * CLK_MHZ + 1;
    // Clocks per machine cycle, marked by the sync pulse
    localparam int SYNC_CYCLES = 15;
    // Reset value of the pulse width register
    localparam logic [7:0] PULSE_RESET = 8'(PULSE_MS);
    // Command codes written with the select line high
    localparam logic [7:0] CMD_READ = 8'h01;
    localparam logic [7:0] CMD_WRITE = 8'h02;
    localparam logic [7:0] CMD_PULSE = 8'h03;
    // Byte left in the output register on an illegal command
    localparam logic [7:0] ILLEGAL_CODE = 8'haa;
    // Status register bit positions
    localparam int ST_OUT_FULL = 0;
    localparam int ST_IN_FULL = 1;
    localparam int ST_BUSY = 2;
    localparam int ST_WAIT_DATA = 3;

    // Memory sequencer states; one bit changes per step except S_ADDR to S_EXPANDER_LATCH_STROBE, S_READ to S_DONE and S_DONE to S_IDLE
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_REQ = 3'h1,
        S_ADDR = 3'h3,
        S_READ = 3'h2,
        S_EXPANDER_LATCH_STROBE = 3'h6,
        S_RECOV = 3'h7,
        S_DONE = 3'h5
    } eepc_state_type;
endpackage : eepc_pkg

/* verification/eepc_ctrl_tb_top.sv */
`timescale 1ns/100ps
// Host-side bench for the memory controller
module eepc_ctrl_tb_top;
    localparam int MS = 10; // Shortened cycles per ms
    localparam int REC = 20; // Shortened recovery wait
    logic clk = 1'b0; // System clock
    logic rst_n = 1'b0; // Reset, active low
    logic cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, sel = 1'b0; // Host strobes
    logic [7:0] din = 8'h00, hdo, mdo, mdi, q; // Data paths
    logic [3:0] gdel = 4'h0, nib; // Grant delay, nibble
    logic [11:0] alo; // Low address
    logic [1:0] ahi; // High address
    logic hoe, full, empt, grant, req_n, ce_n, oe_n, expander_latch_strobe_n, aoe, doe, noe, strb, sync;
    logic [7:0] last_cmd = 8'h00; // Last command byte
    logic [13:0] exp_addr = 14'h0000; // Expected read address
    int error_cnt = 0, num_checks = 0, expander_latch_strobe_cnt = 0, expander_latch_strobe_len = 0, rec_cnt = 0;
    int rec_len = 0, sync_cnt = 0, sync_len = 0;
    always #5 clk = ~clk;
    eepc_ctrl #(.MS_CYCLES(MS), .RECOVER_CYCLES(REC), .SYNC_CYCLES(15)) u_eepc_ctrl (
        .clk(clk), .rst_n(rst_n), .chip_select_n(cs_n), .host_read_n(rd_n),
        .host_write_n(wr_n), .register_select_line(sel), .host_data_in(din),
        .host_data_out(hdo), .host_data_oe(hoe), .output_full_irq(full),
        .input_emptied_irq(empt), .bank_grant(grant), .bank_request_n(req_n),
        .memory_chip_enable_n(ce_n), .memory_output_enable_n(oe_n),
        .programming_enable_n(expander_latch_strobe_n), .memory_address_low_in(aoe ? alo : ~alo),
        .memory_address_low_out(alo), .memory_address_low_oe(aoe),
        .memory_address_high(ahi), .memory_data_in(mdi), .memory_data_out(mdo),
        .memory_data_oe(doe), .expander_nibble_port_in(noe ? nib : ~nib),
        .expander_nibble_port_out(nib), .expander_nibble_port_oe(noe),
        .expander_latch_strobe(strb), .cycle_sync(sync));
    eepc_mem_model u_eepc_mem_model (.clk(clk), .rst_n(rst_n), .grant_delay(gdel),
        .bank_request_n(req_n), .memory_chip_enable_n(ce_n), .memory_output_enable_n(oe_n),
        .programming_enable_n(expander_latch_strobe_n), .address({ahi, alo}), .memory_data_out(mdo),
        .memory_data_oe(doe), .bank_grant(grant), .memory_data_in(mdi));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check
    task automatic check_bit(input logic got, input logic exp);
        check({15'h0, got}, {15'h0, exp});
    endtask : check_bit
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    // Bounded wait on the emptied flag (which=1) or the bus request (which=0)
    task automatic wait_sig(input int which, input logic lvl);
        for (int n = 0; (which ? empt : req_n) !== lvl; n++) begin
            if (n > 3000) begin
                error_cnt++;
                stop_test();
            end
            @(posedge clk);
            #1;
        end
    endtask : wait_sig
    task automatic host_wr(input logic s, input logic [7:0] d);
        @(posedge clk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        sel <= s;
        din <= d;
        if (s)
            last_cmd = d;
        @(posedge clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        #1;
        wait_sig(1, 1'b1);
    endtask : host_wr
    task automatic host_rd(input logic s, output logic [7:0] d);
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        sel <= s;
        @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        #1;
        check_bit(hoe, 1'b1);
        d = hdo;
    endtask : host_rd
    // Ownership, strobe and expander watch, plus pulse, recovery and sync meters
    always @(posedge clk) begin
        if (rst_n) begin
            if (!ce_n)
                check_bit(grant & ~req_n, 1'b1);
            if (!grant)
                check_bit(aoe | doe, 1'b0);
            if (!oe_n)
                check({2'h0, ahi, alo}, {2'h0, exp_addr});
            if (strb)
                check_bit(nib === last_cmd[3:0], 1'b1);
            check_bit(noe, strb);
            if (!expander_latch_strobe_n) begin
                expander_latch_strobe_cnt++;
                rec_cnt = 0;
            end else if (!req_n && expander_latch_strobe_cnt != 0)
                rec_cnt++;
            else if (req_n && expander_latch_strobe_cnt != 0) begin
                expander_latch_strobe_len = expander_latch_strobe_cnt;
                rec_len = rec_cnt;
                expander_latch_strobe_cnt = 0;
            end
            sync_cnt++;
            if (sync) begin
                sync_len = sync_cnt;
                sync_cnt = 0;
            end
        end
    end
    // Whole read command, grant after a chosen delay, then status and data
    task automatic t_read(input logic [13:0] a, input logic [3:0] dly, input logic [7:0] e);
        gdel <= dly;
        exp_addr = a;
        host_wr(1'b1, eepc_pkg::CMD_READ);
        host_wr(1'b0, {2'h0, a[13:8]});
        host_wr(1'b0, a[7:0]);
        wait_sig(0, 1'b0);
        wait_sig(0, 1'b1);
        host_rd(1'b1, q);
        check({8'h0, q}, 16'h0001);
        check_bit(full, 1'b1);
        host_rd(1'b0, q);
        check({8'h0, q}, {8'h0, e});
        check_bit(full, 1'b0);
        $display("read test done at %h", a);
    endtask : t_read
    // Pulse width set, write, meters checked, then read back
    task automatic t_write(input logic [13:0] a, input logic [7:0] d, input logic [7:0] ms);
        host_wr(1'b1, eepc_pkg::CMD_PULSE);
        host_wr(1'b0, ms);
        host_wr(1'b1, eepc_pkg::CMD_WRITE);
        host_wr(1'b0, {2'h0, a[13:8]});
        host_wr(1'b0, a[7:0]);
        host_wr(1'b0, d);
        wait_sig(0, 1'b0);
        wait_sig(0, 1'b1);
        @(posedge clk);
        #1;
        check(16'(expander_latch_strobe_len), 16'((ms == 8'h00 ? 1 : ms) * MS));
        check_bit(rec_len >= REC, 1'b1);
        t_read(a, 4'h3, d);
        $display("write test done");
    endtask : t_write
    // Strobes ignored without chip select, then an illegal command
    task automatic t_misc();
        @(posedge clk);
        wr_n <= 1'b0;
        sel <= 1'b1;
        din <= eepc_pkg::CMD_READ;
        @(posedge clk);
        wr_n <= 1'b1;
        rd_n <= 1'b0;
        @(posedge clk);
        rd_n <= 1'b1;
        #1;
        check_bit(empt, 1'b1);
        check_bit(hoe, 1'b0);
        host_wr(1'b1, 8'h7e);
        host_rd(1'b0, q);
        check({8'h0, q}, {8'h0, eepc_pkg::ILLEGAL_CODE});
        check(16'(sync_len), 16'h000f);
        $display("misc test done");
    endtask : t_misc
    initial begin
        repeat (10) @(posedge clk);
        #1;
        check({9'h0, req_n, ce_n, oe_n, expander_latch_strobe_n, full, empt, hoe}, 16'h007a);
        @(posedge clk);
        rst_n <= 1'b1;
        host_rd(1'b1, q);
        check({8'h0, q}, 16'h0000);
        t_read(14'h3fff, 4'h0, 8'(14'h3fff ^ (14'h3fff >> 6)));
        t_read(14'h1234, 4'h6, 8'(14'h1234 ^ (14'h1234 >> 6)));
        t_write(14'h0155, 8'h5a, 8'h02);
        t_write(14'h2aaa, 8'ha5, 8'h00);
        t_misc();
        stop_test();
    end
endmodule : eepc_ctrl_tb_top

/* verification/eepc_mem_model.sv */
`timescale 1ns/100ps
// Memory bank with its bus arbiter, as seen from the local side
module eepc_mem_model (
    input wire logic clk, // System clock
    input wire logic rst_n, // Reset, active low
    input wire logic [3:0] grant_delay, // Cycles before grant
    input wire logic bank_request_n, // Bus request
    input wire logic memory_chip_enable_n, // Chip enable
    input wire logic memory_output_enable_n, // Read strobe
    input wire logic programming_enable_n, // Programming voltage
    input wire logic [13:0] address, // Full address
    input wire logic [7:0] memory_data_out, // Write data
    input wire logic memory_data_oe, // Write data driven
    output logic bank_grant, // Bus granted
    output logic [7:0] memory_data_in // Read data
);
    logic [7:0] mem [0:16383]; // Bank contents
    logic [3:0] wait_cnt; // Arbitration delay counter
    logic [7:0] last; // Last byte on the bus
    // Fill with a pattern mixing both address halves
    initial begin
        for (int i = 0; i < 16384; i++)
            mem[i] = 8'(i ^ (i >> 6));
    end
    // Grant after a delay, dropped with the request; zero delay is close to a tied grant
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt <= 4'h0;
            bank_grant <= 1'b0;
        end else if (bank_request_n) begin
            wait_cnt <= 4'h0;
            bank_grant <= 1'b0;
        end else if (wait_cnt >= grant_delay) begin
            bank_grant <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
    // Undriven bus toggles so a stale byte can never pass as read data
    assign memory_data_in = (!memory_chip_enable_n && !memory_output_enable_n) ?
        mem[address] : ~last;
    // Store while the programming voltage is applied
    always @(posedge clk) begin
        last <= memory_data_in;
        if (!programming_enable_n && memory_data_oe)
            mem[address] <= memory_data_out;
    end
endmodule : eepc_mem_model
